/* File: rtl/dcs_drive_control.sv */
// drive control word decoder, status word builder and serial port diagnostics
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.svh"

// How it works
// (R01) bit 0 set closes mains contactor
// (R02) standard: bit 1 set enables voltage
// (R03) alternate: bit 1 clear disables voltage
// (R04) bit 2 clear activates quick stop
// (R05) bit 3 set gives run command
// (R06) error cleared only on bit 7 rise
// (R07) profile stop bit issues configured stop
// (R08) standard: bits 13/14 brake/decel, reassignable
// (R09) alternate: bits 13/14 fixed brake/decel
// (R10) standard: bits 11,12,15 user bits
// (R11) new assignment masks default function
// (R12) alternate: bit 8 released source
// (R13) alternate: bit 15 selects local/line
// (R14) status bits 0..3 report state, error
// (R15) status bit 4 mains, profile polarity
// (R16) status bit 5 low on quick stop
// (R17) status bits 6,7 switch-on disabled, warning
// (R18) status bit 9 reports command channel
// (R19) status bit 14 panel stop imposed
// (R20) frame counter, read only, 16 bit
// (R21) crc error counter, read only, 16 bit
// (R22) link activity as four states
// (R23) eight read-only scanner input words
// (R24) reserved control bits written as zero
// (R25) reserved status bits read zero
module dcs_drive_control (
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     clkEn,
   input  wire logic [`DCS_ADDR_W-1:0]   regAddr,
   input  wire logic [15:0]              regWrData,
   input  wire logic                     regWrStrobe,
   input  wire logic                     regRdStrobe,
   output logic      [15:0]              regRdData,
   input  wire logic                     mainsAvailable,
   input  wire logic                     errorDetected,
   input  wire logic                     warningActive,
   input  wire logic                     forcedLocal,
   input  wire logic                     panelStop,
   input  wire logic                     frameDone,
   input  wire logic                     crcError,
   input  wire logic                     rxActive,
   input  wire logic                     txActive,
   input  wire logic [127:0]             scanInWords,
   output logic                          contactorClose,
   output logic                          runCommand,
   output logic                          quickStopActive,
   output logic                          stopCommand,
   output logic      [1:0]               stopType,
   output logic                          brakeStop,
   output logic                          decelStop,
   output logic                          localMode,
   output logic                          cmdReleasedLocal,
   output logic      [15:0]              userBits,
   output logic                          errorAck,
   output logic      [1:0]               netLinkActivity,
   output logic                          netActivityLed
);

   dcs_pkg::dcs_state_s state_reg;
   dcs_pkg::dcs_state_s state_next;

   // scanner input words as an indexed array
   logic [15:0] scanWord [0:7];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_scan
         assign scanWord[gi] = scanInWords[gi*16 +: 16];
      end
   endgenerate

   // saturating increment, shared by both counters
   function automatic logic [15:0] satInc(input logic [15:0] v, input logic ev);
      satInc = v;
      if (ev && v != `DCS_CNT_MAX) begin
         satInc = v + `DCS_CNT_ONE;
      end
   endfunction : satInc

   // a default function only responds while no new function is assigned
   function automatic logic dflt(input logic [15:0] cw, input logic [15:0] asg, input int b);
      dflt = cw[b] & ~asg[b];
   endfunction : dflt

   // profile and decoded enables
   logic isAlt;
   logic voltOk;
   logic [15:0] statusWord;
   logic [15:0] cw;
   assign cw     = state_reg.controlWord;
   assign isAlt  = state_reg.configWord[`DCS_CFG_PROFILE];
   // (R02) (R03) voltage authorization per profile
   assign voltOk = isAlt ? cw[`DCS_C_VOLT] : cw[`DCS_C_VOLT];

   // status word assembly; unlisted bits tie to zero
   always_comb begin
      statusWord = 16'h0000;
      // (R14) state and error report
      statusWord[`DCS_S_READY] = (state_reg.state != dcs_pkg::DCS_ST_DISABLED);
      statusWord[`DCS_S_ON]    = (state_reg.state == dcs_pkg::DCS_ST_ON) || (state_reg.state == dcs_pkg::DCS_ST_RUN);
      statusWord[`DCS_S_OPEN]  = (state_reg.state == dcs_pkg::DCS_ST_RUN);
      statusWord[`DCS_S_ERR]   = state_reg.errLatched;
      // (R15) mains polarity inverted in alternate profile
      statusWord[`DCS_S_MAINS] = isAlt ? ~mainsAvailable : mainsAvailable;
      // (R16) low while quick stop
      statusWord[`DCS_S_NOQS]  = cw[`DCS_C_QSTOP];
      // (R17) switch-on disabled and warning
      statusWord[`DCS_S_SWDIS] = (state_reg.state == dcs_pkg::DCS_ST_DISABLED);
      statusWord[`DCS_S_WARN]  = warningActive;
      // (R18) channel report differs by profile
      statusWord[`DCS_S_CHAN]  = isAlt ? state_reg.localMode : ~forcedLocal;
      // (R19) front-panel stop
      statusWord[`DCS_S_PANEL] = panelStop;
      // (R25) reserved bits stay zero
   end

   // next-state logic for the whole block
   always_comb begin
      state_next = state_reg;
      // register writes; counters and status are read only
      if (regWrStrobe) begin
         case (regAddr)
            // (R24) reserved control bits stored but never decoded
            `DCS_OFF_CTRL:   state_next.controlWord = regWrData;
            `DCS_OFF_CFG:    state_next.configWord  = regWrData;
            `DCS_OFF_ASSIGN: state_next.assignWord  = regWrData & `DCS_ASG_MASK;
            default:         state_next.controlWord = state_reg.controlWord;
         endcase
      end

      // read data is valid in the cycle after the strobe only
      state_next.rdData = 16'h0000;
      if (regRdStrobe) begin
         // compare at full address width so both sides carry the same number of bits
         if ((regAddr >> `DCS_SCAN_BASE_BIT) == (`DCS_OFF_SCAN0 >> `DCS_SCAN_BASE_BIT)) begin
            // (R23) scanner input words
            state_next.rdData = scanWord[regAddr[`DCS_SCAN_BASE_BIT-1:0]];
         end else begin
            case (regAddr)
               `DCS_OFF_CTRL:   state_next.rdData = state_reg.controlWord;
               `DCS_OFF_STAT:   state_next.rdData = statusWord;
               `DCS_OFF_CFG:    state_next.rdData = state_reg.configWord;
               `DCS_OFF_FRAMES: state_next.rdData = state_reg.netFrameCount;
               `DCS_OFF_CRCERR: state_next.rdData = state_reg.netCrcErrorCount;
               `DCS_OFF_LINK:   state_next.rdData = {14'h0000, state_reg.netLinkActivity};
               `DCS_OFF_ASSIGN: state_next.rdData = state_reg.assignWord;
               default:         state_next.rdData = 16'h0000;
            endcase
         end
      end

      // (R06) rising edge of bit 7 acknowledges; a new error wins over the clear
      state_next.errRstPrev = cw[`DCS_C_ERRRST];
      state_next.errorAck   = cw[`DCS_C_ERRRST] & ~state_reg.errRstPrev;
      if (errorDetected) begin
         state_next.errLatched = 1'b1;
      end else if (state_next.errorAck) begin
         state_next.errLatched = 1'b0;
      end

      // power state sequence: voltage, then contactor, then run
      case (state_reg.state)
         dcs_pkg::DCS_ST_DISABLED: begin
            if (voltOk && cw[`DCS_C_QSTOP] && !state_reg.errLatched && !cw[`DCS_C_SWON]) begin
               state_next.state = dcs_pkg::DCS_ST_READY;
            end
         end
         dcs_pkg::DCS_ST_READY: begin
            if (cw[`DCS_C_SWON]) begin
               state_next.state = dcs_pkg::DCS_ST_ON;
            end
         end
         dcs_pkg::DCS_ST_ON: begin
            if (!cw[`DCS_C_SWON]) begin
               state_next.state = dcs_pkg::DCS_ST_READY;
            end else if (cw[`DCS_C_RUN]) begin
               state_next.state = dcs_pkg::DCS_ST_RUN;
            end
         end
         dcs_pkg::DCS_ST_RUN: begin
            if (!cw[`DCS_C_RUN]) begin
               state_next.state = dcs_pkg::DCS_ST_ON;
            end
            if (!cw[`DCS_C_SWON]) begin
               state_next.state = dcs_pkg::DCS_ST_READY;
            end
         end
         default: state_next.state = dcs_pkg::DCS_ST_DISABLED;
      endcase
      // losing voltage, quick stop or an error drops back to disabled
      if (!voltOk || !cw[`DCS_C_QSTOP] || state_reg.errLatched) begin
         state_next.state = dcs_pkg::DCS_ST_DISABLED;
      end

      // (R01) contactor follows switch-on while authorized
      state_next.contactor = cw[`DCS_C_SWON] && voltOk;
      // (R05) run command
      state_next.runCmd    = cw[`DCS_C_RUN] && voltOk && cw[`DCS_C_QSTOP];
      // (R04) quick stop on zero
      state_next.quickStop = ~cw[`DCS_C_QSTOP];
      // (R07) stop bit position depends on profile
      state_next.stopCmd   = isAlt ? cw[`DCS_C_STOP_ALT] : cw[`DCS_C_STOP_STD];
      state_next.stopType  = state_reg.configWord[`DCS_CFG_STT_HI:`DCS_CFG_STT_LO];
      if (isAlt) begin
         // (R09) fixed stop bits in alternate profile
         state_next.brakeStop = cw[`DCS_C_BRAKE];
         state_next.decelStop = cw[`DCS_C_DECEL];
         // (R12) released command source
         state_next.cmdReleased = cw[`DCS_C_REL_ALT];
         // (R13) local/line selection
         state_next.localMode = cw[`DCS_C_LOCAL_ALT];
         state_next.userBits  = 16'h0000;
      end else begin
         // (R08) (R11) default stop functions unless reassigned
         state_next.brakeStop = dflt(cw, state_reg.assignWord, `DCS_C_BRAKE);
         state_next.decelStop = dflt(cw, state_reg.assignWord, `DCS_C_DECEL);
         state_next.cmdReleased = 1'b0;
         state_next.localMode = 1'b0;
         // (R10) (R11) user bits 11,12,15 plus reassigned 13,14
         state_next.userBits  = cw & (`DCS_ASG_MASK | 16'h1800) &
                                ~(16'h6000 & ~state_reg.assignWord);
      end

      // (R20) (R21) saturating diagnostic counters
      state_next.netFrameCount    = satInc(state_reg.netFrameCount, frameDone);
      state_next.netCrcErrorCount = satInc(state_reg.netCrcErrorCount, crcError);
      // (R22) reception/transmission combination
      state_next.netLinkActivity  = dcs_pkg::dcs_link_e'({rxActive, txActive});
      state_next.netActivityLed   = rxActive | txActive;
   end

   // single state register; clock enable freezes everything
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.state <= dcs_pkg::DCS_ST_DISABLED;
         state_reg.controlWord <= `DCS_CTRL_RST;
         state_reg.configWord <= `DCS_CFG_RST;
         state_reg.assignWord <= `DCS_ASSIGN_RST;
      end else if (clkEn) begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign regRdData        = state_reg.rdData;
   assign contactorClose   = state_reg.contactor;
   assign runCommand       = state_reg.runCmd;
   assign quickStopActive  = state_reg.quickStop;
   assign stopCommand      = state_reg.stopCmd;
   assign stopType         = state_reg.stopType;
   assign brakeStop        = state_reg.brakeStop;
   assign decelStop        = state_reg.decelStop;
   assign localMode        = state_reg.localMode;
   assign cmdReleasedLocal = state_reg.cmdReleased;
   assign userBits         = state_reg.userBits;
   assign errorAck         = state_reg.errorAck;
   assign netLinkActivity  = state_reg.netLinkActivity;
   assign netActivityLed   = state_reg.netActivityLed;

endmodule : dcs_drive_control
`default_nettype wire

/* File: inc/dcs_regs.svh */
// register offsets, bit positions and reset values of the drive control/status block
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

`define DCS_ADDR_W          5
`define DCS_OFF_CTRL        5'h00
`define DCS_OFF_STAT        5'h01
`define DCS_OFF_CFG         5'h02
`define DCS_OFF_FRAMES      5'h03
`define DCS_OFF_CRCERR      5'h04
`define DCS_OFF_LINK        5'h05
`define DCS_OFF_ASSIGN      5'h06
`define DCS_OFF_SCAN0       5'h08
`define DCS_SCAN_BASE_BIT   3
`define DCS_CTRL_RST        16'h0000
`define DCS_CFG_RST         16'h0000
`define DCS_ASSIGN_RST      16'h0000
`define DCS_CNT_MAX         16'hffff
`define DCS_CNT_ONE         16'h0001

// control word bits
`define DCS_C_SWON          0
`define DCS_C_VOLT          1
`define DCS_C_QSTOP         2
`define DCS_C_RUN           3
`define DCS_C_ERRRST        7
`define DCS_C_STOP_STD      8
`define DCS_C_REL_ALT       8
`define DCS_C_USER11        11
`define DCS_C_STOP_ALT      12
`define DCS_C_BRAKE         13
`define DCS_C_DECEL         14
`define DCS_C_LOCAL_ALT     15

// status word bits
`define DCS_S_READY         0
`define DCS_S_ON            1
`define DCS_S_OPEN          2
`define DCS_S_ERR           3
`define DCS_S_MAINS         4
`define DCS_S_NOQS          5
`define DCS_S_SWDIS         6
`define DCS_S_WARN          7
`define DCS_S_CHAN          9
`define DCS_S_PANEL         14

// config register bits: profile select, stop type
`define DCS_CFG_PROFILE     0
`define DCS_CFG_STT_LO      1
`define DCS_CFG_STT_HI      2

// assignment register: bit n = 1 means bit n carries a new function
`define DCS_ASG_MASK        16'he800

`endif

/* File: inc/dcs_pkg.sv */
// types shared by the drive control/status block
package dcs_pkg;
   typedef enum logic {
      DCS_STANDARD_PROFILE,
      DCS_ALTERNATE_PROFILE
   } dcs_profile_e;

   typedef enum logic [1:0] {
      DCS_NO_RX_NO_TX,
      DCS_NO_RX_TX,
      DCS_RX_NO_TX,
      DCS_RX_AND_TX
   } dcs_link_e;

   typedef enum logic [1:0] {
      DCS_ST_DISABLED,
      DCS_ST_READY,
      DCS_ST_ON,
      DCS_ST_RUN
   } dcs_state_e;

   typedef struct packed {
      logic [15:0]       controlWord;
      logic [15:0]       configWord;
      logic [15:0]       assignWord;
      logic [15:0]       netFrameCount;
      logic [15:0]       netCrcErrorCount;
      logic              errRstPrev;
      logic              errLatched;
      dcs_state_e        state;
      logic [15:0]       rdData;
      logic              contactor;
      logic              runCmd;
      logic              quickStop;
      logic              stopCmd;
      logic              brakeStop;
      logic              decelStop;
      logic [1:0]        stopType;
      logic              localMode;
      logic              cmdReleased;
      logic [15:0]       userBits;
      logic              errorAck;
      dcs_link_e         netLinkActivity;
      logic              netActivityLed;
   } dcs_state_s;
endpackage : dcs_pkg

/* File: test/dcs_drive_control_props.sv */
// assertion checker for the drive control/status block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.svh"
module dcs_drive_control_props (
   input wire logic          core_clk,
   input wire logic          reset,
   input wire logic          clkEn,
   input wire logic [4:0]    regAddr,
   input wire logic [15:0]   regWrData,
   input wire logic          regWrStrobe,
   input wire logic          regRdStrobe,
   input wire logic [15:0]   regRdData,
   input wire logic          panelStop,
   input wire logic          rxActive,
   input wire logic          txActive,
   input wire logic [127:0]  scanInWords,
   input wire logic          contactorClose,
   input wire logic          runCommand,
   input wire logic          quickStopActive,
   input wire logic [1:0]    stopType,
   input wire logic          errorAck,
   input wire logic [1:0]    netLinkActivity,
   input wire logic          netActivityLed
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // writes and the status read that are taken; decoded outputs follow two edges later with clkEn held
   wire ctrlWr = regWrStrobe && regAddr == `DCS_OFF_CTRL && clkEn;
   wire cfgWr = regWrStrobe && regAddr == `DCS_OFF_CFG && clkEn;
   wire statRd = regRdStrobe && regAddr == `DCS_OFF_STAT && clkEn;

   a_contactor_cmd: assert property (ctrlWr ##1 clkEn |-> ##1
      contactorClose == ($past(regWrData[0], 2) & $past(regWrData[1], 2))) else $error("contactor output wrong");
   a_quick_stop: assert property (ctrlWr ##1 clkEn |-> ##1
      quickStopActive == !$past(regWrData[2], 2)) else $error("quick stop output wrong");
   a_run_needs_power: assert property (ctrlWr ##1 clkEn |-> ##1
      runCommand == (&$past(regWrData[3:1], 2))) else $error("run command output wrong");
   a_stop_type_cfg: assert property (cfgWr ##1 clkEn |-> ##1
      stopType == $past(regWrData[2:1], 2)) else $error("stop type output wrong");
   a_ack_one_pulse: assert property (errorAck && clkEn |=> !errorAck)
      else $error("error acknowledge longer than one cycle");
   a_link_code: assert property (clkEn |=> netLinkActivity == {$past(rxActive), $past(txActive)})
      else $error("link activity code wrong");
   a_led_any_link: assert property (netActivityLed == (netLinkActivity != 2'b00))
      else $error("activity led disagrees with link code");
   a_scan_word_read: assert property (regRdStrobe && clkEn && regAddr[4:3] == 2'b01 |=>
      regRdData == $past(scanInWords[16*regAddr[2:0] +: 16])) else $error("scanner word read wrong");
   a_status_reserved: assert property (statRd |=> (regRdData & 16'hbd00) == 16'h0000)
      else $error("reserved status bits not zero");
   a_panel_stop_bit: assert property (statRd |=> regRdData[14] == $past(panelStop))
      else $error("panel stop status bit wrong");
endmodule : dcs_drive_control_props

bind dcs_drive_control dcs_drive_control_props i_dcs_drive_control_props (
   .core_clk, .reset, .clkEn, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .panelStop,
   .rxActive, .txActive, .scanInWords, .contactorClose, .runCommand, .quickStopActive, .stopType, .errorAck,
   .netLinkActivity, .netActivityLed
);
`default_nettype wire

/* File: test/dcs_cmd_master.sv */
// command master model: issues register writes and reads on the plain port
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.svh"
module dcs_cmd_master (
   input  wire logic         core_clk,
   output logic      [4:0]   regAddr,
   output logic      [15:0]  regWrData,
   output logic              regWrStrobe,
   output logic              regRdStrobe
);
   logic altProfile = 1'b0;

   initial begin
      regAddr = 5'h1f;
      regWrData = 16'h0000;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
   end

   // reserved control bits zero; released lines show the inverse so stale values never pass
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = (a == `DCS_OFF_CTRL) ? (d & ~(altProfile ? 16'h0e70 : 16'h0670)) : d;
      if (a == `DCS_OFF_CFG) altProfile = d[`DCS_CFG_PROFILE];
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= v;
      regWrStrobe <= 1'b1;
      @(posedge core_clk);
      regWrStrobe <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~v;
   endtask : wr

   // one-cycle read strobe; data is collected by the bench in the following cycle
   task automatic rd(input logic [4:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge core_clk);
      regRdStrobe <= 1'b0;
      regAddr <= ~a;
   endtask : rd
endmodule : dcs_cmd_master
`default_nettype wire

/* File: test/dcs_drive_control_tb_top.sv */
// self-checking testbench for the drive control/status block
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin bad_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, act, exp); end end
module dcs_drive_control_tb_top;
   logic          core_clk = 1'b0;
   logic          reset = 1'b1;
   logic          clkEn = 1'b1;
   logic [4:0]    regAddr;
   logic          regWrStrobe, regRdStrobe, errorDetected = 1'b0, frameDone = 1'b0, crcError = 1'b0;
   logic          mainsAvailable = 1'b0, warningActive = 1'b0, forcedLocal = 1'b0, panelStop = 1'b0;
   logic          rxActive = 1'b0, txActive = 1'b0, alt, rdPend = 1'b0;
   logic [127:0]  scanInWords = '0;
   logic          contactorClose, runCommand, quickStopActive, stopCommand, brakeStop, decelStop;
   logic          localMode, cmdReleasedLocal, errorAck, netActivityLed;
   logic [1:0]    stopType, netLinkActivity, stop_type_setting;
   logic [5:0]    expC;
   logic [19:0]   expS;
   logic [15:0]   regWrData, regRdData, userBits, cw, asg, expRd, r;
   logic [15:0]   lfsr = 16'h002a;
   logic [15:0]   q[$];
   logic [15:0]   cwList [6] = '{16'h0000, 16'h0006, 16'h0007, 16'h000f, 16'h0007, 16'h0003};
   logic [2:0]    stList [6] = '{3'b000, 3'b001, 3'b011, 3'b111, 3'b011, 3'b000};
   int            bad_count = 0, checked = 0, ackCount = 0, n;

   dcs_drive_control i_dcs_drive_control (.core_clk, .reset, .clkEn, .regAddr, .regWrData, .regWrStrobe,
      .regRdStrobe, .regRdData, .mainsAvailable, .errorDetected, .warningActive, .forcedLocal, .panelStop,
      .frameDone, .crcError, .rxActive, .txActive, .scanInWords, .contactorClose, .runCommand,
      .quickStopActive, .stopCommand, .stopType, .brakeStop, .decelStop, .localMode, .cmdReleasedLocal,
      .userBits, .errorAck, .netLinkActivity, .netActivityLed);
   dcs_cmd_master i_dcs_cmd_master (.core_clk, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe);

   always #2.5 core_clk = ~core_clk;

   // pseudo random source, fixed start so every run repeats
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd

   // expected status word from state bits, control word, error latch and profile
   function automatic logic [15:0] expStat(input logic [2:0] st, input logic [15:0] c, input logic e,
                                           input logic a);
      expStat = {1'b0, panelStop, 4'h0, a ? c[15] : ~forcedLocal, 1'b0, warningActive, st == 3'b000, c[2],
                 mainsAvailable ^ a, e, st};
   endfunction : expStat

   // read results stand one cycle after the strobe: take the oldest note then
   always @(posedge core_clk) begin
      if (rdPend) begin
         expRd = q.pop_front();
         `CHK(regRdData, expRd)
      end
      rdPend <= regRdStrobe & clkEn;
      if (errorAck === 1'b1) ackCount++;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end
      else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // whole run is a few hundred cycles; this limit of 20000 cycles leaves wide margin
   initial begin
      #100000;
      bad_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      // decode passes: plain, reassigned, restored, alternate
      for (int p = 0; p < 4; p++) begin
         alt = (p == 3);
         asg = p[0] ? 16'h6000 : 16'h0000;
         r = rnd();
         stop_type_setting = r[1:0];
         i_dcs_cmd_master.wr(`DCS_OFF_ASSIGN, asg);
         i_dcs_cmd_master.wr(`DCS_OFF_CFG, {13'h0000, stop_type_setting, alt});
         for (int i = 0; i < 6; i++) begin
            cw = rnd() & ~(alt ? 16'h0e70 : 16'h0670);
            i_dcs_cmd_master.wr(`DCS_OFF_CTRL, cw);
            @(posedge core_clk);
            #1;
            expC = {cw[0] & cw[1], &cw[3:1], !cw[2], alt ? cw[12] : cw[8], stop_type_setting};
            expS = {cw[13] & (alt | !asg[13]), cw[14] & (alt | !asg[14]), alt & cw[15], alt & cw[8],
                    alt ? 16'h0000 : cw & (16'h9800 | asg)};
            `CHK({contactorClose, runCommand, quickStopActive, stopCommand, stopType}, expC)
            `CHK({brakeStop, decelStop, localMode, cmdReleasedLocal, userBits}, expS)
            q.push_back(cw);
            i_dcs_cmd_master.rd(`DCS_OFF_CTRL);
         end
         $display("test decode pass %0d done", p);
      end
      // state walk with random status inputs
      i_dcs_cmd_master.wr(`DCS_OFF_CFG, 16'h0000);
      for (int s = 0; s < 6; s++) begin
         r = rnd();
         @(posedge core_clk);
         {mainsAvailable, warningActive, forcedLocal, panelStop} <= r[3:0];
         i_dcs_cmd_master.wr(`DCS_OFF_CTRL, cwList[s]);
         repeat (3) @(posedge core_clk);
         q.push_back(expStat(stList[s], cwList[s], 1'b0, 1'b0));
         i_dcs_cmd_master.rd(`DCS_OFF_STAT);
      end
      // alternate polarity of mains and channel bits
      i_dcs_cmd_master.wr(`DCS_OFF_CFG, 16'h0001);
      i_dcs_cmd_master.wr(`DCS_OFF_CTRL, 16'h8003);
      repeat (3) @(posedge core_clk);
      q.push_back(expStat(3'b000, 16'h8003, 1'b0, 1'b1));
      i_dcs_cmd_master.rd(`DCS_OFF_STAT);
      i_dcs_cmd_master.wr(`DCS_OFF_CFG, 16'h0000);
      i_dcs_cmd_master.wr(`DCS_OFF_CTRL, 16'h0003);
      $display("test status word done");
      // error latched, cleared by a rising acknowledge only
      @(posedge core_clk);
      errorDetected <= 1'b1;
      @(posedge core_clk);
      errorDetected <= 1'b0;
      repeat (3) @(posedge core_clk);
      q.push_back(expStat(3'b000, 16'h0003, 1'b1, 1'b0));
      i_dcs_cmd_master.rd(`DCS_OFF_STAT);
      ackCount = 0;
      i_dcs_cmd_master.wr(`DCS_OFF_CTRL, 16'h0083);
      repeat (3) @(posedge core_clk);
      q.push_back(expStat(3'b000, 16'h0083, 1'b0, 1'b0));
      i_dcs_cmd_master.rd(`DCS_OFF_STAT);
      i_dcs_cmd_master.wr(`DCS_OFF_CTRL, 16'h0083);
      repeat (3) @(posedge core_clk);
      `CHK(ackCount, 1)
      $display("test error acknowledge done");
      // counters count pulses and ignore writes
      r = rnd();
      n = r[3:0] + 1;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         frameDone <= 1'b1;
         crcError <= i[0];
         @(posedge core_clk);
         frameDone <= 1'b0;
         crcError <= 1'b0;
      end
      i_dcs_cmd_master.wr(`DCS_OFF_FRAMES, 16'hffff);
      // clock enable low: the control write is refused and frame pulses are not counted
      @(posedge core_clk);
      clkEn <= 1'b0;
      frameDone <= 1'b1;
      i_dcs_cmd_master.wr(`DCS_OFF_CTRL, 16'h0000);
      frameDone <= 1'b0;
      clkEn <= 1'b1;
      q.push_back(16'h0083);
      i_dcs_cmd_master.rd(`DCS_OFF_CTRL);
      q.push_back(16'(n));
      i_dcs_cmd_master.rd(`DCS_OFF_FRAMES);
      q.push_back(16'(n / 2));
      i_dcs_cmd_master.rd(`DCS_OFF_CRCERR);
      $display("test counters done");
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         {rxActive, txActive} <= 2'(k);
         repeat (2) @(posedge core_clk);
         #1;
         `CHK({netLinkActivity, netActivityLed}, {2'(k), k != 0})
         q.push_back(16'(k));
         i_dcs_cmd_master.rd(`DCS_OFF_LINK);
      end
      // scanner words, then unmapped reads return zero
      for (int j = 0; j < 8; j++) scanInWords[16*j +: 16] <= rnd();
      @(posedge core_clk);
      for (int j = 0; j < 8; j++) begin
         q.push_back(scanInWords[16*j +: 16]);
         i_dcs_cmd_master.rd(5'(8 + j));
      end
      q.push_back(16'h0000);
      i_dcs_cmd_master.rd(5'h07);
      q.push_back(16'h0000);
      i_dcs_cmd_master.rd(5'h1f);
      repeat (4) @(posedge core_clk);
      $display("test link and scanner done");
      finish_test();
   end
endmodule : dcs_drive_control_tb_top
`default_nettype wire
